/* tax_pkg.sv */
// Constants and types shared by the table access, test-skip and xor block
package tax_pkg;

  // ------------------------------------------------------------
  // Register byte offsets on the bus
  // ------------------------------------------------------------
  localparam logic [7:0] TAX_REG_INSTR  = 8'h00; // Instruction issue
  localparam logic [7:0] TAX_REG_CTRL   = 8'h04; // Mode and bank control
  localparam logic [7:0] TAX_REG_WREG   = 8'h08; // Working register
  localparam logic [7:0] TAX_REG_STATUS = 8'h0c; // Flags and state
  localparam logic [7:0] TAX_REG_TABLE_POINTER = 8'h10; // Table pointer
  localparam logic [7:0] TAX_REG_TBLLAT = 8'h14; // Table latch
  localparam logic [7:0] TAX_REG_HOLD0  = 8'h20; // First holding register
  localparam logic [7:0] TAX_REG_HOLD7  = 8'h3c; // Last holding register

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TAX_INSTR_TWO_WORD_BIT = 16; // Next instruction has two words
  localparam int TAX_CTRL_EXT_BIT       = 0;  // Extended set enable
  localparam int TAX_CTRL_BANK_LSB      = 8;  // Bank select field
  localparam int TAX_STAT_Z_BIT         = 0;  // Zero flag
  localparam int TAX_STAT_N_BIT         = 1;  // Negative flag
  localparam int TAX_STAT_BUSY_BIT      = 8;  // Instruction in progress
  localparam int TAX_STAT_SKIP_BIT      = 9;  // Last test skipped

  // ------------------------------------------------------------
  // Opcode patterns, pointer modes, addressing limits
  // ------------------------------------------------------------
  localparam logic [13:0] TAX_OPC_TABLE_READ_OP  = 14'h0002; // Bits 15:2
  localparam logic [13:0] TAX_OPC_TABLE_WRITE_OP  = 14'h0003; // Bits 15:2
  localparam logic [6:0]  TAX_OPC_TST    = 7'h33;    // Bits 15:9
  localparam logic [7:0]  TAX_OPC_XORL   = 8'h0a;    // Bits 15:8
  localparam logic [5:0]  TAX_OPC_XORF   = 6'h06;    // Bits 15:10
  localparam logic [1:0]  TAX_MODE_HOLD  = 2'h0;     // Pointer unchanged
  localparam logic [1:0]  TAX_MODE_POSTI = 2'h1;     // Post-increment
  localparam logic [1:0]  TAX_MODE_POSTD = 2'h2;     // Post-decrement
  localparam logic [1:0]  TAX_MODE_PREI  = 2'h3;     // Pre-increment
  localparam logic [7:0]  TAX_ACCESS_LOW_MAX = 8'h5f; // Low access / index limit
  localparam logic [3:0]  TAX_ACCESS_HIGH_BANK = 4'hf; // Upper access half
  localparam int          TAX_PTR_W     = 21;        // Table pointer width
  localparam int          TAX_HOLD_N    = 8;         // Holding registers

  // Decoded operations
  typedef enum logic [2:0] {
    TAX_OP_NOP, TAX_OP_TABLE_READ_OP, TAX_OP_TABLE_WRITE_OP, TAX_OP_TST, TAX_OP_XORL, TAX_OP_XORF
  } tax_op_type;

endpackage

/* tax_bank_addr.sv */
// File register address resolver: access bank, banked and indexed modes
`timescale 1ns/100ps
`default_nettype none

module tax_bank_addr (
  // Operand fields
  input  wire logic [7:0]  file_in,      // 8-bit file operand
  input  wire logic        access_in,    // Bank mode bit
  // Mode state
  input  wire logic        ext_en_in,    // Extended set enabled
  input  wire logic [3:0]  bank_in,      // Bank select register
  input  wire logic [11:0] index_base_in, // Index pointer for literal offset
  // Result
  output logic [11:0]      addr_out,     // Full data address
  output logic             indexed_out   // Indexed literal offset used
);

  // ------------------------------------------------------------
  // Address selection
  // ------------------------------------------------------------
  // Indexed mode only steals the low access half, so upper access
  // registers stay reachable with the extension on.
  always_comb begin
    indexed_out = 1'b0;
    if (access_in) begin
      addr_out = {bank_in, file_in};
    end else if (ext_en_in && (file_in <= tax_pkg::TAX_ACCESS_LOW_MAX)) begin
      addr_out    = 12'(index_base_in + {4'h0, file_in});
      indexed_out = 1'b1;
    end else if (file_in <= tax_pkg::TAX_ACCESS_LOW_MAX) begin
      addr_out = {4'h0, file_in};
    end else begin
      addr_out = {tax_pkg::TAX_ACCESS_HIGH_BANK, file_in};
    end
  end

endmodule
`default_nettype wire

/* tax_core.sv */
// Execution core for table access, test-skip-if-zero and xor instructions
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none

module tax_core #(
  parameter int PTR_W  = tax_pkg::TAX_PTR_W,  // Table pointer width
  parameter int HOLD_N = tax_pkg::TAX_HOLD_N  // Holding register count
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // Wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  // Program memory read port
  output logic [PTR_W-2:0]       pm_word_addr_out,
  output logic                   pm_rd_out,
  input  wire logic [15:0]       pm_word_in,
  // File register port
  output logic [11:0]            fr_addr_out,
  output logic                   fr_rd_out,
  input  wire logic [7:0]        fr_rdata_in,
  output logic                   fr_wr_out,
  output logic [7:0]             fr_wdata_out,
  input  wire logic [11:0]       index_base_in,
  // Pipeline status
  output logic                   busy_out,
  output logic                   flush_out
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TAX_ST_IDLE, TAX_ST_EXEC1, TAX_ST_EXEC2, TAX_ST_FLUSH1, TAX_ST_FLUSH2
  } tax_state_type;

  tax_state_type       state_reg;          // Execution state
  tax_pkg::tax_op_type op_reg;             // Operation in flight
  logic [15:0]         instr_reg;          // Issued instruction word
  logic                two_word_reg;       // Next instruction has two words
  logic                ext_en_reg;         // Extended set enable
  logic [3:0]          bank_reg;           // Bank select register
  logic [7:0]          wreg_reg;           // Working register
  logic                zero_reg;           // Zero flag
  logic                neg_reg;            // Negative flag
  logic                skip_reg;           // Last test skipped
  logic [PTR_W-1:0]    table_pointer_reg;  // Program byte pointer
  logic [7:0]          table_latch_reg;    // Table latch
  logic [7:0]          hold_reg [HOLD_N];  // Programming holding registers
  logic [7:0]          xor_res;            // Xor result
  logic [11:0]         bank_addr;          // Resolved file address
  logic                bus_req;            // New bus access
  logic                bus_wr;             // Write strobe
  logic                issue;              // Instruction accepted
  tax_pkg::tax_op_type issue_op;           // Decode of written word
  logic [1:0]          mode;               // Pointer mode field
  logic [31:0]         rd_mux;             // Read data select
  logic [PTR_W-1:0]    ptr_bus;            // Pointer after bus write

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Opcode decode of the written word, latched into op_reg at issue
  function automatic tax_pkg::tax_op_type decode_op(input logic [15:0] w);
    tax_pkg::tax_op_type r;
    r = tax_pkg::TAX_OP_NOP;
    if (w[15:2] == tax_pkg::TAX_OPC_TABLE_READ_OP) r = tax_pkg::TAX_OP_TABLE_READ_OP;
    else if (w[15:2] == tax_pkg::TAX_OPC_TABLE_WRITE_OP) r = tax_pkg::TAX_OP_TABLE_WRITE_OP;
    else if (w[15:9] == tax_pkg::TAX_OPC_TST) r = tax_pkg::TAX_OP_TST;
    else if (w[15:8] == tax_pkg::TAX_OPC_XORL) r = tax_pkg::TAX_OP_XORL;
    else if (w[15:10] == tax_pkg::TAX_OPC_XORF) r = tax_pkg::TAX_OP_XORF;
    return r;
  endfunction

  // Pointer step; the sum is cut back to the pointer width so it wraps
  function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
                                                input logic up);
    logic [PTR_W-1:0] one;
    one = {{(PTR_W-1){1'b0}}, 1'b1};
    return up ? PTR_W'(p + one) : PTR_W'(p - one);
  endfunction

  // Byte lane merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Address resolution
  // ------------------------------------------------------------
  tax_bank_addr u_bank_addr (
    .file_in       (wb_dat_in[7:0]),
    .access_in     (wb_dat_in[8]),
    .ext_en_in     (ext_en_reg),
    .bank_in       (bank_reg),
    .index_base_in (index_base_in),
    .addr_out      (bank_addr),
    .indexed_out   ()
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // One access per ack; the ack term keeps a held request from repeating
  assign bus_req  = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr   = bus_req && wb_we_in;
  assign issue_op = decode_op(wb_dat_in[15:0]);
  // Issue needs the low two lanes; writes while busy are dropped
  assign issue    = bus_wr && (wb_adr_in == tax_pkg::TAX_REG_INSTR) &&
                    (wb_sel_in[1:0] == 2'h3) && (state_reg == TAX_ST_IDLE);
  assign mode     = instr_reg[1:0];
  assign xor_res  = wreg_reg ^ ((op_reg == tax_pkg::TAX_OP_XORL) ?
                                instr_reg[7:0] : fr_rdata_in);
  assign ptr_bus  = PTR_W'(merge(32'(table_pointer_reg), wb_dat_in, wb_sel_in));

  // Read data select; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0;
    case (wb_adr_in)
      tax_pkg::TAX_REG_INSTR:  rd_mux = {15'h0, two_word_reg, instr_reg};
      tax_pkg::TAX_REG_CTRL:   rd_mux = {20'h0, bank_reg, 7'h0, ext_en_reg};
      tax_pkg::TAX_REG_WREG:   rd_mux = {24'h0, wreg_reg};
      tax_pkg::TAX_REG_STATUS: begin
        rd_mux[tax_pkg::TAX_STAT_Z_BIT]    = zero_reg;
        rd_mux[tax_pkg::TAX_STAT_N_BIT]    = neg_reg;
        rd_mux[tax_pkg::TAX_STAT_BUSY_BIT] = busy_out;
        rd_mux[tax_pkg::TAX_STAT_SKIP_BIT] = skip_reg;
      end
      tax_pkg::TAX_REG_TABLE_POINTER: rd_mux = 32'(table_pointer_reg);
      tax_pkg::TAX_REG_TBLLAT: rd_mux = {24'h0, table_latch_reg};
      default: begin
        if (wb_adr_in >= tax_pkg::TAX_REG_HOLD0 && wb_adr_in <= tax_pkg::TAX_REG_HOLD7 &&
            wb_adr_in[1:0] == 2'h0) begin
          rd_mux = {24'h0, hold_reg[wb_adr_in[4:2]]};
        end
      end
    endcase
  end

  // Registered ack and read data, one cycle after the request
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? rd_mux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // One clock stands for one full four-phase instruction cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= TAX_ST_IDLE;
      op_reg    <= tax_pkg::TAX_OP_NOP;
    end else begin
      case (state_reg)
        TAX_ST_IDLE: begin
          if (issue) begin
            state_reg <= TAX_ST_EXEC1;
            op_reg    <= issue_op;
          end
        end
        TAX_ST_EXEC1: begin
          if (op_reg == tax_pkg::TAX_OP_TABLE_READ_OP || op_reg == tax_pkg::TAX_OP_TABLE_WRITE_OP) begin
            state_reg <= TAX_ST_EXEC2;
          end else if (op_reg == tax_pkg::TAX_OP_TST && fr_rdata_in == 8'h00) begin
            state_reg <= TAX_ST_FLUSH1;
          end else begin
            state_reg <= TAX_ST_IDLE;
          end
        end
        TAX_ST_EXEC2: state_reg <= TAX_ST_IDLE;
        TAX_ST_FLUSH1: state_reg <= two_word_reg ? TAX_ST_FLUSH2 : TAX_ST_IDLE;
        TAX_ST_FLUSH2: state_reg <= TAX_ST_IDLE;
        default: state_reg <= TAX_ST_IDLE;
      endcase
    end
  end

  // Busy and flush indication for the fetch pipeline
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      busy_out  <= 1'b0;
      flush_out <= 1'b0;
    end else begin
      busy_out  <= issue || (state_reg == TAX_ST_EXEC1 &&
                   (op_reg == tax_pkg::TAX_OP_TABLE_READ_OP || op_reg == tax_pkg::TAX_OP_TABLE_WRITE_OP ||
                    (op_reg == tax_pkg::TAX_OP_TST && fr_rdata_in == 8'h00))) ||
                   (state_reg == TAX_ST_FLUSH1 && two_word_reg);
      // Each flushed word runs as a no-operation cycle
      flush_out <= (state_reg == TAX_ST_EXEC1 && op_reg == tax_pkg::TAX_OP_TST &&
                    fr_rdata_in == 8'h00) ||
                   (state_reg == TAX_ST_FLUSH1 && two_word_reg);
    end
  end

  // ------------------------------------------------------------
  // Instruction word and control
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      instr_reg    <= 16'h0;
      two_word_reg <= 1'b0;
      ext_en_reg   <= 1'b0;
      bank_reg     <= 4'h0;
    end else begin
      if (issue) begin
        instr_reg    <= wb_dat_in[15:0];
        two_word_reg <= wb_dat_in[tax_pkg::TAX_INSTR_TWO_WORD_BIT];
      end
      if (bus_wr && wb_adr_in == tax_pkg::TAX_REG_CTRL) begin
        if (wb_sel_in[0]) ext_en_reg <= wb_dat_in[tax_pkg::TAX_CTRL_EXT_BIT];
        if (wb_sel_in[1]) bank_reg <= wb_dat_in[tax_pkg::TAX_CTRL_BANK_LSB +: 4];
      end
    end
  end

  // ------------------------------------------------------------
  // File register port
  // ------------------------------------------------------------
  // Address and read strobe go out at issue so data is back in EXEC1
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fr_addr_out  <= 12'h0;
      fr_rd_out    <= 1'b0;
      fr_wr_out    <= 1'b0;
      fr_wdata_out <= 8'h0;
    end else begin
      fr_rd_out <= issue && (issue_op == tax_pkg::TAX_OP_TST ||
                             issue_op == tax_pkg::TAX_OP_XORF);
      if (issue) fr_addr_out <= bank_addr;
      fr_wr_out <= 1'b0;
      if (state_reg == TAX_ST_EXEC1 && op_reg == tax_pkg::TAX_OP_XORF &&
          instr_reg[9]) begin
        fr_wr_out    <= 1'b1;
        fr_wdata_out <= xor_res;
      end
    end
  end

  // ------------------------------------------------------------
  // Working register and flags
  // ------------------------------------------------------------
  // Execution wins over a bus write landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wreg_reg <= 8'h0;
      zero_reg <= 1'b0;
      neg_reg  <= 1'b0;
      skip_reg <= 1'b0;
    end else begin
      if (bus_wr && wb_adr_in == tax_pkg::TAX_REG_WREG && wb_sel_in[0]) begin
        wreg_reg <= wb_dat_in[7:0];
      end
      if (bus_wr && wb_adr_in == tax_pkg::TAX_REG_STATUS && wb_sel_in[0]) begin
        zero_reg <= wb_dat_in[tax_pkg::TAX_STAT_Z_BIT];
        neg_reg  <= wb_dat_in[tax_pkg::TAX_STAT_N_BIT];
      end
      if (state_reg == TAX_ST_EXEC1) begin
        case (op_reg)
          tax_pkg::TAX_OP_XORL: begin
            wreg_reg <= xor_res;
            zero_reg <= (xor_res == 8'h00);
            neg_reg  <= xor_res[7];
          end
          tax_pkg::TAX_OP_XORF: begin
            if (!instr_reg[9]) wreg_reg <= xor_res;
            zero_reg <= (xor_res == 8'h00);
            neg_reg  <= xor_res[7];
          end
          tax_pkg::TAX_OP_TST: skip_reg <= (fr_rdata_in == 8'h00);
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Table pointer and program memory port
  // ------------------------------------------------------------
  // Pre-increment lands in EXEC1, post steps in EXEC2 after the access
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      table_pointer_reg <= '0;
      pm_word_addr_out  <= '0;
      pm_rd_out         <= 1'b0;
    end else begin
      pm_rd_out <= 1'b0;
      if (state_reg == TAX_ST_EXEC1 && op_reg == tax_pkg::TAX_OP_TABLE_READ_OP) begin
        pm_rd_out        <= 1'b1;
        pm_word_addr_out <= (mode == tax_pkg::TAX_MODE_PREI) ?
                            (PTR_W-1)'(step_ptr(table_pointer_reg, 1'b1) >> 1) :
                            (PTR_W-1)'(table_pointer_reg >> 1);
      end
      if (state_reg == TAX_ST_EXEC1 && mode == tax_pkg::TAX_MODE_PREI &&
          (op_reg == tax_pkg::TAX_OP_TABLE_READ_OP || op_reg == tax_pkg::TAX_OP_TABLE_WRITE_OP)) begin
        table_pointer_reg <= step_ptr(table_pointer_reg, 1'b1);
      end else if (state_reg == TAX_ST_EXEC2 && (mode == tax_pkg::TAX_MODE_POSTI ||
                   mode == tax_pkg::TAX_MODE_POSTD)) begin
        table_pointer_reg <= step_ptr(table_pointer_reg,
                                      mode == tax_pkg::TAX_MODE_POSTI);
      end else if (bus_wr && wb_adr_in == tax_pkg::TAX_REG_TABLE_POINTER && !busy_out) begin
        table_pointer_reg <= ptr_bus;
      end
    end
  end

  // ------------------------------------------------------------
  // Table latch and holding registers
  // ------------------------------------------------------------
  // Holding registers only stage data for a later flash program run
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      table_latch_reg <= 8'h0;
      for (int i = 0; i < HOLD_N; i++) hold_reg[i] <= 8'h0;
    end else begin
      if (state_reg == TAX_ST_EXEC2 && op_reg == tax_pkg::TAX_OP_TABLE_READ_OP) begin
        // Pointer still holds the accessed address during EXEC2
        table_latch_reg <= table_pointer_reg[0] ? pm_word_in[15:8] :
                                                  pm_word_in[7:0];
      end else if (bus_wr && wb_adr_in == tax_pkg::TAX_REG_TBLLAT && wb_sel_in[0] &&
                   !busy_out) begin
        table_latch_reg <= wb_dat_in[7:0];
      end
      if (state_reg == TAX_ST_EXEC2 && op_reg == tax_pkg::TAX_OP_TABLE_WRITE_OP) begin
        hold_reg[table_pointer_reg[2:0]] <= table_latch_reg;
      end
    end
  end

endmodule
`default_nettype wire

/* tax_core_sva.sv */
// Concurrent checks on the core's bus, table and skip timing
`timescale 1ns/100ps
`default_nettype none
module tax_core_sva (
  // Watched ports
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic        pm_rd_out,
  input wire logic        fr_rd_out,
  input wire logic        fr_wr_out,
  input wire logic        busy_out,
  input wire logic        flush_out
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus ack late");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus ack held");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data without ack");
  a_rd_second: assert property (pm_rd_out |-> busy_out && $past(busy_out))
    else $error("memory read not in second cycle");
  a_rd_ends: assert property (pm_rd_out |=> !pm_rd_out && !busy_out)
    else $error("table read overran");
  a_test_first: assert property (fr_rd_out |-> busy_out && !$past(busy_out))
    else $error("file read not at issue");
  a_wr_after_rd: assert property (fr_wr_out |-> $past(fr_rd_out) && !busy_out)
    else $error("file write misplaced");
  a_flush_busy: assert property (flush_out |-> busy_out && $past(busy_out))
    else $error("flush outside skip");
  a_flush_max: assert property (flush_out ##1 flush_out |=> !flush_out && !busy_out)
    else $error("too many flush cycles");
  a_busy_max: assert property (busy_out [*3] |=> !busy_out)
    else $error("instruction too long");
endmodule
bind tax_core tax_core_sva u_sva (.clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
  .wb_dat_out, .pm_rd_out, .fr_rd_out, .fr_wr_out, .busy_out, .flush_out);
`default_nettype wire

/* tax_mem_model.sv */
// Program memory and file register model facing the core
`timescale 1ns/100ps
`default_nettype none
module tax_mem_model (
  // Clock
  input  wire logic        clk_in,
  // Program memory
  input  wire logic [19:0] pm_word_addr_in,
  input  wire logic        pm_rd_in,
  output var  logic [15:0] pm_word_out,
  // File registers
  input  wire logic [11:0] fr_addr_in,
  input  wire logic        fr_wr_in,
  input  wire logic [7:0]  fr_wdata_in,
  output logic [7:0]       fr_rdata_out
);
  logic [7:0]  mem [0:4095]; // File space, preloaded by the bench
  logic [15:0] word;         // Address-derived word contents
  // Word stands in the same cycle as the strobe, since the core latches it then;
  // between reads the inverse shows so that stale data is caught
  assign word        = {pm_word_addr_in[7:0] ^ 8'h5a, pm_word_addr_in[7:0] ^ 8'h3c};
  assign pm_word_out = pm_rd_in ? word : ~word;
  // Combinational read, write on strobe
  assign fr_rdata_out = mem[fr_addr_in];
  always @(posedge clk_in) begin
    if (fr_wr_in) begin
      mem[fr_addr_in] <= fr_wdata_in;
    end
  end
endmodule
`default_nettype wire

/* table_access_test_xor_ops_tb.sv */
// Self-checking bench for the table access, test-skip and xor core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module table_access_test_xor_ops_tb;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
  logic        wb_we_in = 1'b0, wb_ack_out, pm_rd_out, fr_rd_out, fr_wr_out, busy_out, flush_out;
  logic [7:0]  wb_adr_in = 8'h00, fr_rdata_in, fr_wdata_out, w, k;
  logic [3:0]  wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, e, m, exp_q[$], msk_q[$];
  logic [11:0] index_base_in = 12'h100, fr_addr_out;
  logic [19:0] pm_word_addr_out;
  logic [15:0] pm_word_in;
  logic [20:0] p, q, s;
  logic [1:0]  md;
  int          n_fail = 0, total_checks = 0, n_flush, n_busy, i, j;
  always #20 clk_in = ~clk_in;
  tax_core DUT (.clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .pm_word_addr_out, .pm_rd_out, .pm_word_in,
    .fr_addr_out, .fr_rd_out, .fr_rdata_in, .fr_wr_out, .fr_wdata_out, .index_base_in,
    .busy_out, .flush_out);
  tax_mem_model P (.clk_in, .pm_word_addr_in(pm_word_addr_out), .pm_rd_in(pm_rd_out),
    .pm_word_out(pm_word_in), .fr_addr_in(fr_addr_out), .fr_wr_in(fr_wr_out),
    .fr_wdata_in(fr_wdata_out), .fr_rdata_out(fr_rdata_in));
  // Classic cycle held until ack is seen; no latency assumed
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_in);
      t++;
    end while (wb_ack_out !== 1'b1 && t < 50);
    if (wb_ack_out !== 1'b1) n_fail++;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  // Read with its expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
    exp_q.push_back(x);
    msk_q.push_back(mk);
    bus(1'b0, a, 32'h0);
  endtask
  // Issue one instruction and wait until the core is idle again
  task automatic run(input logic [31:0] ins);
    n_flush = 0;
    n_busy = 0;
    bus(1'b1, 8'h00, ins);
    do @(posedge clk_in); while (busy_out === 1'b1 && n_busy < 9);
  endtask
  // Monitor: oldest expectation against each read answer
  always @(posedge clk_in) begin
    n_flush += flush_out;
    n_busy += busy_out;
    if (wb_ack_out === 1'b1 && !wb_we_in && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(wb_dat_out & m, e)
    end
  end
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    final_report();
  end
  initial begin
    void'($urandom(9));
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(8'hfc, 32'h0, 32'hffffffff);
    bus(1'b1, 8'h08, 32'hb5);
    run(32'h0aaf);
    rd(8'h08, 32'h1a, 32'hff);
    `CHK(n_busy, 1)
    w = 8'h1a;
    for (i = 0; i < 4; i++) begin
      k = (i == 3) ? w : 8'($urandom);
      run({16'h0, 8'h0a, k});
      w = w ^ k;
      rd(8'h0c, {30'h0, w[7], w == 8'h0}, 32'h203);
    end
    // File xor: banked with d=1, access bank with d=0, then indexed
    P.mem[12'h234] = 8'haf;
    P.mem[12'hf80] = 8'h0f;
    P.mem[12'h110] = 8'hba;
    bus(1'b1, 8'h04, 32'h200);
    bus(1'b1, 8'h08, 32'hb5);
    run({16'h0, 6'h06, 2'b11, 8'h34});
    @(posedge clk_in);
    `CHK(P.mem[12'h234], 8'h1a)
    rd(8'h08, 32'hb5, 32'hff);
    run({16'h0, 6'h06, 2'b00, 8'h80});
    rd(8'h08, 32'hba, 32'hff);
    bus(1'b1, 8'h04, 32'h201);
    run({16'h0, 6'h06, 2'b00, 8'h10});
    rd(8'h0c, 32'h1, 32'h203);
    // Test-skip: no skip, skip, skip over a two-word instruction; N left set
    bus(1'b1, 8'h0c, 32'h2);
    P.mem[12'h235] = 8'h00;
    for (i = 0; i < 3; i++) begin
      run({15'h0, i[1], 7'h33, 1'b1, 7'h1a, i != 0});
      `CHK(n_busy, i + 1)
      `CHK(n_flush, i)
      rd(8'h0c, {22'h0, i != 0, 7'h0, 2'h2}, 32'h203);
    end
    // Table read then write in every pointer mode, last pass wraps the pointer
    for (i = 0; i < 5; i++) begin
      p = (i == 4) ? 21'h1fffff : 21'h0a357 + 21'(i);
      md = i[1:0] ^ {1'b0, i[2]};
      q = (md == 2'h0) ? p : (md == 2'h2) ? p - 21'h1 : p + 21'h1;
      s = (md == 2'h3) ? q : p;
      k = s[8:1] ^ (s[0] ? 8'h5a : 8'h3c);
      for (j = 0; j < 2; j++) begin
        bus(1'b1, 8'h10, {11'h0, p});
        run({16'h0, 13'h1, j[0], md});
        rd(8'h10, {11'h0, q}, 32'h1fffff);
        rd(j == 0 ? 8'h14 : 8'h20 + {3'h0, s[2:0], 2'h0}, {24'h0, k}, 32'hff);
      end
    end
    @(posedge clk_in);
    final_report();
  end
endmodule
`default_nettype wire
